// ===== common/bbrc_regs.svh
// register offsets, field positions, reset values and timing counts of the rate and cca control block
// assumes inclusion by bare name from package and design files
`ifndef BBRC_REGS_SVH
`define BBRC_REGS_SVH
`define BBRC_ADDR_W 16
`define BBRC_OFS_FORCE_OFF 16'h2201
`define BBRC_OFS_RATE 16'h2211
`define BBRC_OFS_CCA_CTL 16'h222c
`define BBRC_OFS_THRESH 16'h222d
`define BBRC_OFS_STATUS 16'h2230
`define BBRC_RST_FORCE_OFF 8'h03
`define BBRC_RST_RATE 8'h06
`define BBRC_RST_CCA_CTL 8'h20
`define BBRC_RST_THRESH 8'hb2
`define BBRC_FO_TX_BIT 1
`define BBRC_FO_RX_BIT 0
`define BBRC_CODE_LSB 4
`define BBRC_RATE_LSB 0
`define BBRC_IDLE_OVR_BIT 5
`define BBRC_WIN_LSB 2
`define BBRC_METH_LSB 0
`define BBRC_CLK_MHZ 10
`define BBRC_WIN_1US 1
`define BBRC_WIN_2US 2
`define BBRC_WIN_4US 4
`define BBRC_WIN_8US 8
`define BBRC_WIN_16US 16
`endif

// ===== common/bbrc_pkg.sv
// types of the rate and cca control block
// assumes bbrc_regs.svh is on the include path
`include "bbrc_regs.svh"
package bbrc_pkg;
  typedef enum logic [1:0] {
    BBRC_SENSE_ENERGY = 2'h0,
    BBRC_SENSE_CARRIER = 2'h1,
    BBRC_SENSE_FRAME = 2'h2,
    BBRC_SENSE_RSVD = 2'h3
  } bbrc_sense_t;
  typedef enum logic [2:0] {
    BBRC_TX_IDLE = 3'b001,
    BBRC_TX_DEFER = 3'b010,
    BBRC_TX_SEND = 3'b100
  } bbrc_txst_t;
endpackage : bbrc_pkg

// ===== common/bbrc_cca_if.sv
// interface between the control top and the energy window measurer
// assumes one clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface bbrc_cca_if;
  logic [2:0] win_sel;
  logic sampling;
  logic [7:0] energy;
  logic [7:0] thresh;
  logic busy;
  logic valid;
  modport ctl (output win_sel, output sampling, output energy, output thresh, input busy, input valid);
  modport meas (input win_sel, input sampling, input energy, input thresh, output busy, output valid);
endinterface : bbrc_cca_if
`default_nettype wire

// ===== design/bbrc_energy_win.sv
// energy detector: takes peak energy over a selectable window and compares with threshold
// assumes energy samples arrive synchronous to REF_CLK, one per cycle
`timescale 1ns/1ns
`default_nettype none
`include "bbrc_regs.svh"
module bbrc_energy_win (
  input wire logic clk,
  input wire logic rst,
  bbrc_cca_if.meas cca
);
  import bbrc_pkg::*;
  localparam int C1 = `BBRC_WIN_1US * `BBRC_CLK_MHZ;
  localparam int C2 = `BBRC_WIN_2US * `BBRC_CLK_MHZ;
  localparam int C4 = `BBRC_WIN_4US * `BBRC_CLK_MHZ;
  localparam int C8 = `BBRC_WIN_8US * `BBRC_CLK_MHZ;
  localparam int C16 = `BBRC_WIN_16US * `BBRC_CLK_MHZ;

  function automatic logic [7:0] win_len(input logic [2:0] sel);
    case (sel)
      3'h0: win_len = 8'(C1);
      3'h1: win_len = 8'(C2);
      3'h2: win_len = 8'(C4);
      3'h3: win_len = 8'(C8);
      default: win_len = 8'(C16);
    endcase
  endfunction : win_len

  logic [7:0] cnt_reg;
  logic [7:0] peak_reg;
  logic busy_reg;
  logic valid_reg;
  // peak rather than sum keeps the compare 8 bits wide at any window length
  wire [7:0] len = win_len(cca.win_sel);
  wire last = cca.sampling && (cnt_reg >= len - 8'h01);
  wire [7:0] peak_now = (cca.energy > peak_reg) ? cca.energy : peak_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      peak_reg <= 8'h00;
      busy_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else if (!cca.sampling) begin
      cnt_reg <= 8'h00;
      peak_reg <= 8'h00;
      valid_reg <= 1'b0;
    end else if (last) begin
      cnt_reg <= 8'h00;
      peak_reg <= 8'h00;
      busy_reg <= peak_now > cca.thresh;
      valid_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      peak_reg <= peak_now;
    end
  end
  assign cca.busy = busy_reg;
  assign cca.valid = valid_reg;

  AST_WIN_ONE_US: assert property (@(posedge clk) disable iff (rst)
    (cca.sampling && cca.win_sel == 3'h0 && cnt_reg == 8'h09) |=> cnt_reg == 8'h00)
    else $error("one microsecond window did not close after ten cycles");
endmodule : bbrc_energy_win
`default_nettype wire

// ===== design/bbrc_ctrl.sv
// top of the rate and cca control block: register port, power override, transmit gate
// assumes energy, carrier and frame indications synchronous to REF_CLK; phy inputs from pins
`timescale 1ns/1ns
`default_nettype none
`include "bbrc_regs.svh"
module bbrc_ctrl (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [`BBRC_ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic PHY_TX_ON,
  input wire logic PHY_RX_ON,
  input wire logic RX_PACKET,
  input wire logic [7:0] ENERGY,
  input wire logic CARRIER_DET,
  input wire logic FRAME_DET,
  input wire logic TX_REQ,
  input wire logic TX_DONE,
  output logic TX_GO,
  output logic TX_PWR,
  output logic RX_PWR,
  output logic CHANNEL_IDLE,
  output logic [1:0] CODING_RATE,
  output logic [3:0] AIR_RATE,
  output logic RATE_VALID,
  output bbrc_pkg::bbrc_sense_t SENSE_METHOD
);
  import bbrc_pkg::*;

  // registers
  logic [7:0] force_off_reg;
  logic [7:0] rate_reg;
  logic [7:0] cca_ctl_reg;
  logic [7:0] thresh_reg;
  logic [7:0] rdata_reg;
  bbrc_txst_t tx_st_reg;
  bbrc_txst_t tx_st_next;
  logic tx_pwr_reg;
  logic rx_pwr_reg;
  logic idle_reg;
  logic tx_go_reg;
  logic rate_ok_reg;

  // pin inputs: three stages, a change counts when stages two and three agree
  logic [2:0] ptx_sync;
  logic [2:0] prx_sync;
  logic ptx_reg;
  logic prx_reg;

  bbrc_cca_if cca ();

  function automatic logic rate_legal(input logic [3:0] rate, input logic [1:0] code);
    case (rate)
      4'h0: rate_legal = (code == 2'h1);
      4'h1, 4'h2, 4'h3, 4'h5, 4'h9: rate_legal = 1'b1;
      default: rate_legal = 1'b0;
    endcase
  endfunction : rate_legal

  // address decode
  wire sel_fo = (ADDR == `BBRC_OFS_FORCE_OFF);
  wire sel_rate = (ADDR == `BBRC_OFS_RATE);
  wire sel_cca = (ADDR == `BBRC_OFS_CCA_CTL);
  wire sel_thr = (ADDR == `BBRC_OFS_THRESH);
  wire sel_sts = (ADDR == `BBRC_OFS_STATUS);

  // fields
  wire tx_force = force_off_reg[`BBRC_FO_TX_BIT];
  wire rx_enable = force_off_reg[`BBRC_FO_RX_BIT];
  wire [1:0] code_sel = rate_reg[`BBRC_CODE_LSB +: 2];
  wire [3:0] rate_sel = rate_reg[`BBRC_RATE_LSB +: 4];
  wire idle_ovr = cca_ctl_reg[`BBRC_IDLE_OVR_BIT];
  wire [2:0] win_sel = cca_ctl_reg[`BBRC_WIN_LSB +: 3];
  bbrc_sense_t method;
  assign method = bbrc_sense_t'(cca_ctl_reg[`BBRC_METH_LSB +: 2]);

  // reserved bits are stored as written; software keeps them zero
  wire [7:0] status_word = {3'h0, tx_st_reg, idle_reg, cca.busy};
  wire [7:0] rd_mux = sel_fo ? force_off_reg :
                      sel_rate ? rate_reg :
                      sel_cca ? cca_ctl_reg :
                      sel_thr ? thresh_reg :
                      sel_sts ? status_word : 8'h00;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      force_off_reg <= `BBRC_RST_FORCE_OFF;
      rate_reg <= `BBRC_RST_RATE;
      cca_ctl_reg <= `BBRC_RST_CCA_CTL;
      thresh_reg <= `BBRC_RST_THRESH;
    end else if (WR) begin
      if (sel_fo) force_off_reg <= WDATA;
      if (sel_rate) rate_reg <= WDATA;
      if (sel_cca) cca_ctl_reg <= WDATA;
      if (sel_thr) thresh_reg <= WDATA;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) rdata_reg <= 8'h00;
    else if (RD) rdata_reg <= rd_mux;
    else rdata_reg <= 8'h00;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ptx_sync <= 3'h0;
      prx_sync <= 3'h0;
      ptx_reg <= 1'b0;
      prx_reg <= 1'b0;
    end else begin
      ptx_sync <= {ptx_sync[1:0], PHY_TX_ON};
      prx_sync <= {prx_sync[1:0], PHY_RX_ON};
      if (ptx_sync[2] == ptx_sync[1]) ptx_reg <= ptx_sync[2];
      if (prx_sync[2] == prx_sync[1]) prx_reg <= prx_sync[2];
    end
  end

  // energy measurement runs whenever no packet is being received
  assign cca.sampling = !RX_PACKET;
  assign cca.energy = ENERGY;
  assign cca.thresh = thresh_reg;
  assign cca.win_sel = win_sel;

  bbrc_energy_win u_win (
    .clk(REF_CLK),
    .rst(RST),
    .cca(cca.meas)
  );

  // busy criterion by method; window only matters through the energy path
  wire busy_sel = (method == BBRC_SENSE_ENERGY) ? cca.busy :
                  (method == BBRC_SENSE_CARRIER) ? CARRIER_DET :
                  (method == BBRC_SENSE_FRAME) ? FRAME_DET : 1'b0;
  // reserved method never blocks, so a bad setting cannot hang the transmitter
  wire idle_next = idle_ovr | ~busy_sel;

  // transmit gate
  always_comb begin
    tx_st_next = tx_st_reg;
    unique case (tx_st_reg)
      BBRC_TX_IDLE: begin
        if (TX_REQ) tx_st_next = idle_reg ? BBRC_TX_SEND : BBRC_TX_DEFER;
      end
      BBRC_TX_DEFER: begin
        if (idle_reg) tx_st_next = BBRC_TX_SEND;
      end
      BBRC_TX_SEND: begin
        if (TX_DONE) tx_st_next = BBRC_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      tx_st_reg <= BBRC_TX_IDLE;
      tx_go_reg <= 1'b0;
      idle_reg <= 1'b0;
      tx_pwr_reg <= 1'b0;
      rx_pwr_reg <= 1'b0;
      rate_ok_reg <= 1'b0;
    end else begin
      tx_st_reg <= tx_st_next;
      tx_go_reg <= (tx_st_next == BBRC_TX_SEND);
      idle_reg <= idle_next;
      tx_pwr_reg <= ptx_reg & ~tx_force;
      rx_pwr_reg <= prx_reg & rx_enable;
      rate_ok_reg <= rate_legal(rate_sel, code_sel);
    end
  end

  assign RDATA = rdata_reg;
  assign TX_GO = tx_go_reg;
  assign TX_PWR = tx_pwr_reg;
  assign RX_PWR = rx_pwr_reg;
  assign CHANNEL_IDLE = idle_reg;
  assign CODING_RATE = code_sel;
  assign AIR_RATE = rate_sel;
  assign RATE_VALID = rate_ok_reg;
  assign SENSE_METHOD = method;

  AST_TX_FORCED_OFF: assert property (@(posedge REF_CLK) disable iff (RST)
    $past(tx_force) |-> !TX_PWR)
    else $error("transmitter powered while forced off");
  AST_RX_FORCED_OFF: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(rx_enable) |-> !RX_PWR)
    else $error("receiver powered while forced off");
  AST_TX_FOLLOWS_PHY: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(tx_force) |-> TX_PWR == $past(ptx_reg))
    else $error("transmit power differs from phy command");
  AST_RX_FOLLOWS_PHY: assert property (@(posedge REF_CLK) disable iff (RST)
    $past(rx_enable) |-> RX_PWR == $past(prx_reg))
    else $error("receive power differs from phy command");
  AST_OVERRIDE_IDLE: assert property (@(posedge REF_CLK) disable iff (RST)
    (!$past(RST) && $past(idle_ovr)) |-> CHANNEL_IDLE)
    else $error("channel busy despite idle override");
  AST_SEND_ONLY_IDLE: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(TX_GO) |-> $past(idle_reg))
    else $error("transmission started on busy channel");
  AST_DEFER_BUSY: assert property (@(posedge REF_CLK) disable iff (RST)
    (tx_st_reg == BBRC_TX_DEFER && !idle_reg) |=> !TX_GO)
    else $error("deferred packet sent while busy");
  AST_DEFER_RELEASE: assert property (@(posedge REF_CLK) disable iff (RST)
    (tx_st_reg == BBRC_TX_DEFER && idle_reg) |=> TX_GO)
    else $error("deferred packet not released when idle");
  AST_CARRIER_BUSY: assert property (@(posedge REF_CLK) disable iff (RST)
    (method == BBRC_SENSE_CARRIER && !idle_ovr && CARRIER_DET) |=> !CHANNEL_IDLE)
    else $error("carrier detect did not mark channel busy");
  AST_WIN_IGNORED: assert property (@(posedge REF_CLK) disable iff (RST)
    (method == BBRC_SENSE_FRAME && !idle_ovr) |=> CHANNEL_IDLE == !$past(FRAME_DET))
    else $error("frame method decision not from frame detect");
  AST_RATE_1M: assert property (@(posedge REF_CLK) disable iff (RST)
    (rate_sel == 4'h0 && code_sel != 2'h1) |=> !RATE_VALID)
    else $error("1 mbps accepted without coding rate one");
  AST_THRESH_RESET: assert property (@(posedge REF_CLK)
    $fell(RST) |-> thresh_reg == 8'hb2)
    else $error("threshold reset value wrong");

  // rate table: listed codes valid, 0 only with coding rate one, the rest never
  AST_RATE_LISTED: assert property (@(posedge REF_CLK) disable iff (RST)
    (rate_sel == 4'h1 || rate_sel == 4'h2 || rate_sel == 4'h3 ||
     rate_sel == 4'h5 || rate_sel == 4'h9) |=> RATE_VALID)
    else $error("listed air rate not accepted");
  AST_RATE_UNLISTED: assert property (@(posedge REF_CLK) disable iff (RST)
    !(rate_sel == 4'h0 || rate_sel == 4'h1 || rate_sel == 4'h2 ||
      rate_sel == 4'h3 || rate_sel == 4'h5 || rate_sel == 4'h9) |=> !RATE_VALID)
    else $error("unlisted air rate accepted");
  AST_CODED_1M: assert property (@(posedge REF_CLK) disable iff (RST)
    (rate_sel == 4'h0 && code_sel == 2'h1) |=> RATE_VALID)
    else $error("1 mbps with coding rate one refused");
  // decision source per method
  AST_ENERGY_DECIDES: assert property (@(posedge REF_CLK) disable iff (RST)
    (method == BBRC_SENSE_ENERGY && !idle_ovr) |=> CHANNEL_IDLE == !$past(cca.busy))
    else $error("energy method decision not from energy detector");
  AST_RESERVED_IDLE: assert property (@(posedge REF_CLK) disable iff (RST)
    (method == BBRC_SENSE_RSVD) |=> CHANNEL_IDLE)
    else $error("reserved method marked channel busy");
  AST_PACKET_HOLDS: assert property (@(posedge REF_CLK) disable iff (RST)
    RX_PACKET |=> cca.busy == $past(cca.busy))
    else $error("energy decision changed during packet");
  // transmit gate sequencing
  AST_IDLE_SEND: assert property (@(posedge REF_CLK) disable iff (RST)
    (tx_st_reg == BBRC_TX_IDLE && TX_REQ && idle_reg) |=> TX_GO)
    else $error("request on idle channel not sent");
  AST_IDLE_DEFER: assert property (@(posedge REF_CLK) disable iff (RST)
    (tx_st_reg == BBRC_TX_IDLE && TX_REQ && !idle_reg) |=> (tx_st_reg == BBRC_TX_DEFER && !TX_GO))
    else $error("request on busy channel not deferred");
  AST_SEND_HOLDS: assert property (@(posedge REF_CLK) disable iff (RST)
    (tx_st_reg == BBRC_TX_SEND && !TX_DONE) |=> TX_GO)
    else $error("send dropped before done");
  AST_STATE_ONEHOT: assert property (@(posedge REF_CLK) disable iff (RST)
    $onehot(tx_st_reg))
    else $error("transmit state not one-hot");

  COV_DEFER: cover property (@(posedge REF_CLK) disable iff (RST)
    tx_st_reg == BBRC_TX_DEFER ##[1:50] TX_GO);
  COV_DIRECT: cover property (@(posedge REF_CLK) disable iff (RST)
    tx_st_reg == BBRC_TX_IDLE && TX_REQ && idle_reg);
  COV_ENERGY_BUSY: cover property (@(posedge REF_CLK) disable iff (RST)
    method == BBRC_SENSE_ENERGY && cca.busy);
  COV_PACKET_PAUSE: cover property (@(posedge REF_CLK) disable iff (RST)
    RX_PACKET && method == BBRC_SENSE_ENERGY && cca.busy);
  COV_OVERRIDE_SEND: cover property (@(posedge REF_CLK) disable iff (RST)
    idle_ovr && TX_GO);
endmodule : bbrc_ctrl
`default_nettype wire

// ===== verif/bbrc_rf_model.sv
// rf front end and shared channel model: energy, carrier and frame levels, end of send
// assumes REF_CLK domain; channel state set by the bench
`timescale 1ns/1ns
`default_nettype none
module bbrc_rf_model #(
  parameter int SEND_LEN = 6
) (
  input wire logic clk,
  input wire logic ch_busy,
  input wire logic carrier,
  input wire logic frame,
  input wire logic tx_go,
  output logic [7:0] energy,
  output logic carrier_det,
  output logic frame_det,
  output logic tx_done
);
  int cnt;
  bit tog;
  always_ff @(posedge clk) begin
    tog <= !tog;
    cnt <= tx_go ? cnt + 1 : 0;
  end
  // quiet channel still wanders, so a sticky sample is not enough to pass
  assign energy = ch_busy ? (tog ? 8'hf0 : 8'hc0) : (tog ? 8'h10 : 8'h40);
  assign carrier_det = carrier;
  assign frame_det = frame;
  assign tx_done = tx_go && (cnt == SEND_LEN);
endmodule : bbrc_rf_model
`default_nettype wire

// ===== verif/test_bbrc_ctrl.sv
// self-checking bench of the rate and cca control block
// assumes bbrc_rf_model as the far side; registers reached over the plain strobe port
`timescale 1ns/1ns
`default_nettype none
module test_bbrc_ctrl;
  import bbrc_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, tx_req = 0, ptx = 1, prx = 1;
  logic busy = 0, carr = 0, frm = 0, rx_pkt = 0;
  logic [15:0] addr = 0;
  logic [7:0] wdata = 0, rdata, energy;
  logic cdet, fdet, tx_done, tx_go, tx_pwr, rx_pwr, ch_idle, rate_ok;
  logic [1:0] code;
  logic [3:0] air;
  bbrc_sense_t meth;
  int bad_count = 0, cmp_count = 0;
  logic [3:0] rates [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h9};
  always #50 clk = !clk;
  bbrc_ctrl dut (.REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .PHY_TX_ON(ptx), .PHY_RX_ON(prx), .RX_PACKET(rx_pkt), .ENERGY(energy), .CARRIER_DET(cdet),
    .FRAME_DET(fdet), .TX_REQ(tx_req), .TX_DONE(tx_done), .TX_GO(tx_go), .TX_PWR(tx_pwr),
    .RX_PWR(rx_pwr), .CHANNEL_IDLE(ch_idle), .CODING_RATE(code), .AIR_RATE(air),
    .RATE_VALID(rate_ok), .SENSE_METHOD(meth));
  bbrc_rf_model rf (.clk(clk), .ch_busy(busy), .carrier(carr), .frame(frm), .tx_go(tx_go),
    .energy(energy), .carrier_det(cdet), .frame_det(fdet), .tx_done(tx_done));
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk
  task wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask : wreg
  task rreg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a; rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    chk(rdata, exp, "read");
  endtask : rreg
  // bounded wait for a level, then judged
  task automatic wait_for(ref logic s, input logic v, input string m);
    int n;
    n = 0;
    @(negedge clk);
    while (s !== v && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk({7'h0, s}, {7'h0, v}, m);
  endtask : wait_for
  task t_reset;
    rreg(16'h2201, 8'h03);
    rreg(16'h2211, 8'h06);
    rreg(16'h222c, 8'h20);
    rreg(16'h222d, 8'hb2);
    wreg(16'h2202, 8'h5a);
    rreg(16'h2202, 8'h00);
  endtask : t_reset
  task t_power;
    repeat (6) @(negedge clk);
    chk({6'h0, tx_pwr, rx_pwr}, 8'h01, "forced tx off");
    wreg(16'h2201, 8'h00);
    repeat (3) @(negedge clk);
    chk({6'h0, tx_pwr, rx_pwr}, 8'h02, "forced rx off");
    wreg(16'h2201, 8'h01);
    @(posedge clk) ptx <= 0;
    repeat (7) @(negedge clk);
    chk({6'h0, tx_pwr, rx_pwr}, 8'h01, "phy decides");
    @(posedge clk) prx <= 0;
    repeat (7) @(negedge clk);
    chk({6'h0, tx_pwr, rx_pwr}, 8'h00, "phy decides rx");
  endtask : t_power
  task t_rate;
    for (int i = 0; i < 6; i++) begin
      wreg(16'h2211, {4'h1, rates[i]});
      repeat (2) @(negedge clk);
      chk({3'h0, rate_ok, air}, {4'h1, rates[i]}, "rate");
    end
    for (int c = 0; c < 4; c++) begin
      wreg(16'h2211, {2'h0, c[1:0], 4'h2});
      repeat (2) @(negedge clk);
      chk({5'h0, rate_ok, code}, {6'h1, c[1:0]}, "coding");
    end
    wreg(16'h2211, 8'h20);
    repeat (2) @(negedge clk);
    chk({7'h0, rate_ok}, 8'h00, "1 Mbps needs coding 1");
  endtask : t_rate
  task t_defer;
    wreg(16'h222c, 8'h00);
    @(posedge clk) busy <= 1;
    wait_for(ch_idle, 1'b0, "energy busy");
    @(posedge clk) begin
      rx_pkt <= 1;
      busy <= 0;
    end
    repeat (30) @(negedge clk);
    chk({7'h0, ch_idle}, 8'h00, "decision held during packet");
    @(posedge clk) begin
      rx_pkt <= 0;
      busy <= 1;
    end
    @(posedge clk) tx_req <= 1;
    @(posedge clk) tx_req <= 0;
    repeat (30) @(negedge clk);
    chk({7'h0, tx_go}, 8'h00, "send held");
    rreg(16'h2230, 8'h09);
    @(posedge clk) busy <= 0;
    wait_for(tx_go, 1'b1, "send after idle");
    wait_for(tx_go, 1'b0, "send ends");
    wreg(16'h222d, 8'hff);
    @(posedge clk) busy <= 1;
    repeat (40) @(negedge clk);
    chk({7'h0, ch_idle}, 8'h01, "below threshold");
    wreg(16'h222d, 8'hb2);
  endtask : t_defer
  task t_method;
    wreg(16'h222c, 8'h09);
    repeat (40) @(negedge clk);
    chk({6'h0, meth}, 8'h01, "carrier mode, energy ignored");
    chk({7'h0, ch_idle}, 8'h01, "carrier mode idle");
    @(posedge clk) carr <= 1;
    wait_for(ch_idle, 1'b0, "carrier busy");
    wreg(16'h222c, 8'h02);
    wait_for(ch_idle, 1'b1, "frame mode idle");
    @(posedge clk) frm <= 1;
    wait_for(ch_idle, 1'b0, "frame busy");
    wreg(16'h222c, 8'h03);
    wait_for(ch_idle, 1'b1, "reserved idle");
    wreg(16'h222c, 8'h08);
    wait_for(ch_idle, 1'b0, "long window busy");
    @(posedge clk) busy <= 0;
    repeat (35) @(negedge clk);
    chk({7'h0, ch_idle}, 8'h00, "four us window still open");
    wait_for(ch_idle, 1'b1, "four us window closes");
    @(posedge clk) busy <= 1;
    wait_for(ch_idle, 1'b0, "busy before override");
    wreg(16'h222c, 8'h28);
    wait_for(ch_idle, 1'b1, "override idle");
    @(posedge clk) tx_req <= 1;
    @(posedge clk) tx_req <= 0;
    wait_for(tx_go, 1'b1, "send under override");
    wait_for(tx_go, 1'b0, "send ends");
  endtask : t_method
  task test_done;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    t_reset();
    t_power();
    t_rate();
    t_defer();
    t_method();
    test_done();
  end
  // whole run is well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule : test_bbrc_ctrl
`default_nettype wire
